// ---- src/mft_consts.svh ----
// Overview of operation
// R1 - Two 8-bit control registers per timer
// R2 - Interrupts only from compare, capture, overflow
// R3 - Capture two sets bit 7, sticky
// R4 - Capture one sets bit 6, sticky
// R5 - Bit 5 enables capture interrupts
// R6 - Match on second value sets bit 4
// R7 - Match on first value sets bit 3
// R8 - Bit 2 enables comparison interrupts
// R9 - Counter wrap sets bit 1, sticky
// R10 - Real-time counter wrap sets control-B bit 7
// R11 - Bit 6 selects capture edge polarity
// R12 - Bit 5 selects event edge polarity
// R13 - Prescaler divides clock by two-power code
// R14 - Bits 1:0 select the operating mode
// R15 - PWM restarts, alternates values, toggles output
// R16 - Software timer like PWM, output unchanged
// R17 - Capture mode free-runs, captures load registers
// R18 - Capture mode match toggles output, no restart
// R19 - Bit 0 enables overflow interrupts
// R20 - Irq while flag and enable; set wins
// R21 - Inputs synchronised before edge detection
`ifndef MFT_CONSTS_SVH
`define MFT_CONSTS_SVH

// ***************************************
// Register map
// ***************************************
`define MFT_ADDR_W   8
`define MFT_OFF_A    8'h00
`define MFT_OFF_B    8'h04
`define MFT_OFF_CMP1 8'h08
`define MFT_OFF_CMP2 8'h0C
`define MFT_OFF_CAP  8'h10
`define MFT_OFF_CNT  8'h14
`define MFT_OFF_RTC  8'h18

// ***************************************
// Control A fields
// ***************************************
`define MFT_A_CPF2 7
`define MFT_A_CPF1 6
`define MFT_A_CPIE 5
`define MFT_A_CMF2 4
`define MFT_A_CMF1 3
`define MFT_A_CMIE 2
`define MFT_A_OVF  1
`define MFT_A_OVIE 0
`define MFT_A_FLAG_MASK 8'hDA
`define MFT_A_EN_MASK   8'h25

// ***************************************
// Control B fields
// ***************************************
`define MFT_B_RTOV  7
`define MFT_B_CPEDG 6
`define MFT_B_EXEDG 5
`define MFT_B_PS_HI 4
`define MFT_B_PS_LO 2
`define MFT_B_MC_HI 1
`define MFT_B_MC_LO 0

// ***************************************
// Reset values and limits
// ***************************************
`define MFT_RST_BYTE 8'h00
`define MFT_RST_WORD 16'h0000
`define MFT_CNT_MAX  16'hFFFF
`define MFT_RT_MAX   8'hFF
`define MFT_RESP_OK  2'b00
`define MFT_RESP_ERR 2'b10

`endif

// ---- src/mft_pkg.sv ----
// ***************************************
// Shared types
// ***************************************
package mft_pkg;
  // Operating modes in field order
  typedef enum logic [1:0] {
    MFT_SW,
    MFT_PWM,
    MFT_CC,
    MFT_EXT
  } mft_mode_t;
endpackage : mft_pkg

// ---- src/mft_edge_det.sv ----
`timescale 1ns/10ps
`default_nettype none
// ***************************************
// Pin synchroniser and edge detector
// ***************************************
module mft_edge_det (
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  input  wire logic pin_i,
  input  wire logic rise_sel_i,
  output logic      edge_o
);
  logic s1_q;   // First stage, read by s2 only
  logic s2_q;   // Second stage
  logic prev_q; // Last synchronised level

  // R21 sync then detect
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      s1_q   <= 1'b0;
      s2_q   <= 1'b0;
      prev_q <= 1'b0;
    end
    else
    begin
      s1_q   <= pin_i;
      s2_q   <= s1_q;
      prev_q <= s2_q;
    end
  end

  // R21 one pulse per edge
  assign edge_o = rise_sel_i ? (s2_q & ~prev_q) : (~s2_q & prev_q);
endmodule : mft_edge_det
`default_nettype wire

// ---- src/mft_prescaler.sv ----
`timescale 1ns/10ps
`default_nettype none
// ***************************************
// Power-of-two clock prescaler
// ***************************************
module mft_prescaler #(
  parameter int SEL_W = 3
) (
  input  wire logic             clk_i,
  input  wire logic             arst_n_i,
  input  wire logic [SEL_W-1:0] sel_i,
  output logic                  tick_o
);
  localparam int CW = (2 ** SEL_W) - 1;

  logic [CW-1:0] div_q; // Free-running divider
  logic [CW-1:0] mask;  // Low bits that must be all ones

  // Divider runs every clock
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      div_q <= '0;
    else
      div_q <= div_q + 1'b1;
  end

  // R13 tick every 2**sel
  assign mask   = ~({CW{1'b1}} << sel_i);
  assign tick_o = ((div_q & mask) == mask);
endmodule : mft_prescaler
`default_nettype wire

// ---- src/mft_ctrl.sv ----
// Decided for this implementation: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "mft_consts.svh"
// ***************************************
// Multi-function timer with AXI4-Lite registers
// ***************************************
module mft_ctrl (
  input  wire logic                   clk_i,
  input  wire logic                   arst_n_i,
  // Write address channel
  input  wire logic [`MFT_ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic                   s_axi_awvalid_i,
  output logic                        s_axi_awready_o,
  // Write data channel
  input  wire logic [31:0]            s_axi_wdata_i,
  input  wire logic [3:0]             s_axi_wstrb_i,
  input  wire logic                   s_axi_wvalid_i,
  output logic                        s_axi_wready_o,
  // Write response channel
  output logic [1:0]                  s_axi_bresp_o,
  output logic                        s_axi_bvalid_o,
  input  wire logic                   s_axi_bready_i,
  // Read address channel
  input  wire logic [`MFT_ADDR_W-1:0] s_axi_araddr_i,
  input  wire logic                   s_axi_arvalid_i,
  output logic                        s_axi_arready_o,
  // Read data channel
  output logic [31:0]                 s_axi_rdata_o,
  output logic [1:0]                  s_axi_rresp_o,
  output logic                        s_axi_rvalid_o,
  input  wire logic                   s_axi_rready_i,
  // Timer pins
  input  wire logic                   cap1_pin_i,
  input  wire logic                   cap2_pin_i,
  input  wire logic                   event_pin_i,
  output logic                        wave_o,
  output logic                        irq_o
);
  import mft_pkg::*;

  // ***************************************
  // Declarations
  // ***************************************
  // R1 two control bytes
  logic [7:0]  ctrl_a_q;   // Flags and enables
  logic [7:0]  ctrl_a_d;
  logic [7:0]  ctrl_b_q;   // Mode, prescale, edges
  logic [7:0]  ctrl_b_d;
  logic [15:0] cmp1_q;     // First compare value
  logic [15:0] cmp2_q;     // Second compare value
  logic [15:0] cap_q;      // Read-only capture
  logic [15:0] cnt_q;      // Timer counter
  logic        sel2_q;     // Second value active
  logic        wave_q;     // Waveform output
  logic        irq_q;      // Interrupt output
  logic [7:0]  rtc_q;      // Real-time counter

  // Bus state
  logic                   awready_q;
  logic                   wready_q;
  logic                   bvalid_q;
  logic [1:0]             bresp_q;
  logic                   aw_have_q;
  logic                   w_have_q;
  logic [`MFT_ADDR_W-1:0] awaddr_q;
  logic [31:0]            wdata_q;
  logic [3:0]             wstrb_q;
  logic                   arready_q;
  logic                   rvalid_q;
  logic [1:0]             rresp_q;
  logic [31:0]            rdata_q;

  // Internal events
  mft_mode_t   mode;       // Decoded mode
  logic        cc;         // Capture/compare mode
  logic        psc_tick;   // Prescaled tick
  logic        ev_edge;    // External event edge
  logic        cap1_edge;  // Capture one edge
  logic        cap2_edge;  // Capture two edge
  logic        tick;       // Counter advance
  logic [15:0] act_cmp;    // Active compare value
  logic        match;      // Counter equals active
  logic        restart;    // Match that restarts
  logic        wrap;       // Counter overflow
  logic        cap1_ev;    // Qualified capture one
  logic        cap2_ev;    // Qualified capture two
  logic        rt_wrap;    // Real-time wrap
  logic        wr_en;      // Write commits
  logic [2:0]  wr_idx;     // Write target
  logic        wr_lo;      // Low byte strobe
  logic        wr_hi;      // Second byte strobe

  // ***************************************
  // Address decode
  // ***************************************
  // Returns register index, 7 when unmapped
  function automatic logic [2:0] reg_idx(input logic [`MFT_ADDR_W-1:0] a);
    case (a)
      `MFT_OFF_A:    reg_idx = 3'd0;
      `MFT_OFF_B:    reg_idx = 3'd1;
      `MFT_OFF_CMP1: reg_idx = 3'd2;
      `MFT_OFF_CMP2: reg_idx = 3'd3;
      `MFT_OFF_CAP:  reg_idx = 3'd4;
      `MFT_OFF_CNT:  reg_idx = 3'd5;
      `MFT_OFF_RTC:  reg_idx = 3'd6;
      default:       reg_idx = 3'd7;
    endcase
  endfunction : reg_idx

  // ***************************************
  // Pin front ends
  // ***************************************
  // R11 capture edge polarity
  mft_edge_det u_cap1 (
    .clk_i      (clk_i),
    .arst_n_i   (arst_n_i),
    .pin_i      (cap1_pin_i),
    .rise_sel_i (ctrl_b_q[`MFT_B_CPEDG]),
    .edge_o     (cap1_edge)
  );

  mft_edge_det u_cap2 (
    .clk_i      (clk_i),
    .arst_n_i   (arst_n_i),
    .pin_i      (cap2_pin_i),
    .rise_sel_i (ctrl_b_q[`MFT_B_CPEDG]),
    .edge_o     (cap2_edge)
  );

  // R12 event edge polarity
  mft_edge_det u_event (
    .clk_i      (clk_i),
    .arst_n_i   (arst_n_i),
    .pin_i      (event_pin_i),
    .rise_sel_i (ctrl_b_q[`MFT_B_EXEDG]),
    .edge_o     (ev_edge)
  );

  // R13 prescaled timer clock
  mft_prescaler #(
    .SEL_W (3)
  ) u_psc (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .sel_i    (ctrl_b_q[`MFT_B_PS_HI:`MFT_B_PS_LO]),
    .tick_o   (psc_tick)
  );

  // ***************************************
  // Event decode
  // ***************************************
  // R14 mode field
  assign mode = mft_mode_t'(ctrl_b_q[`MFT_B_MC_HI:`MFT_B_MC_LO]);
  assign cc   = (mode == MFT_CC);
  // External mode counts pin edges instead
  assign tick    = (mode == MFT_EXT) ? ev_edge : psc_tick;
  // Capture mode compares against the first value only
  assign act_cmp = (cc || !sel2_q) ? cmp1_q : cmp2_q;
  assign match   = tick && (cnt_q == act_cmp);
  assign restart = match && !cc;
  // R9 wrap from all ones
  assign wrap    = tick && !restart && (cnt_q == `MFT_CNT_MAX);
  // R17 captures only in capture mode
  assign cap1_ev = cc && cap1_edge;
  assign cap2_ev = cc && cap2_edge;
  assign rt_wrap = (rtc_q == `MFT_RT_MAX);
  // Write commits once address and data are both held
  assign wr_en   = aw_have_q && w_have_q && !bvalid_q;
  assign wr_idx  = reg_idx(awaddr_q);
  assign wr_lo   = wr_en && wstrb_q[0];
  assign wr_hi   = wr_en && wstrb_q[1];

  // ***************************************
  // Control A next value
  // ***************************************
  // Flags survive only where 1 is written; enables take the written value
  function automatic logic [7:0] ctrl_a_wr(input logic [7:0] old, input logic [7:0] w);
    ctrl_a_wr = (old & w & `MFT_A_FLAG_MASK) | (w & `MFT_A_EN_MASK);
  endfunction : ctrl_a_wr

  // Writing 0 clears a flag, 1 keeps it
  always_comb
  begin
    ctrl_a_d = ctrl_a_q;
    if (wr_lo && wr_idx == 3'd0)
    begin
      ctrl_a_d = ctrl_a_wr(ctrl_a_q, wdata_q[7:0]);
    end
    // R20 set wins over clear
    // R3 capture two flag
    if (cap2_ev)
      ctrl_a_d[`MFT_A_CPF2] = 1'b1;
    // R4 capture one flag
    if (cap1_ev)
      ctrl_a_d[`MFT_A_CPF1] = 1'b1;
    // R6 second match flag
    if (restart && sel2_q)
      ctrl_a_d[`MFT_A_CMF2] = 1'b1;
    // R7 first match flag
    if (match && (cc || !sel2_q))
      ctrl_a_d[`MFT_A_CMF1] = 1'b1;
    // R9 overflow flag
    if (wrap)
      ctrl_a_d[`MFT_A_OVF] = 1'b1;
  end

  // ***************************************
  // Control B next value
  // ***************************************
  always_comb
  begin
    ctrl_b_d = ctrl_b_q;
    if (wr_lo && wr_idx == 3'd1)
    begin
      ctrl_b_d[6:0] = wdata_q[6:0];
      ctrl_b_d[`MFT_B_RTOV] = ctrl_b_q[`MFT_B_RTOV] & wdata_q[7];
    end
    // R10 real-time wrap flag
    if (rt_wrap)
      ctrl_b_d[`MFT_B_RTOV] = 1'b1;
  end

  // ***************************************
  // Control registers
  // ***************************************
  // Written with reset value zero
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ctrl_a_q <= `MFT_RST_BYTE;
      ctrl_b_q <= `MFT_RST_BYTE;
    end
    else
    begin
      ctrl_a_q <= ctrl_a_d;
      ctrl_b_q <= ctrl_b_d;
    end
  end

  // ***************************************
  // Interrupt output
  // ***************************************
  // R2 three event classes
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      irq_q <= 1'b0;
    else
      // R5 R8 R19 R20 gated flags
      irq_q <= ((ctrl_a_d[`MFT_A_CPF2] | ctrl_a_d[`MFT_A_CPF1]) & ctrl_a_d[`MFT_A_CPIE])
             | ((ctrl_a_d[`MFT_A_CMF2] | ctrl_a_d[`MFT_A_CMF1]) & ctrl_a_d[`MFT_A_CMIE])
             | (ctrl_a_d[`MFT_A_OVF] & ctrl_a_d[`MFT_A_OVIE]);
  end

  // ***************************************
  // Compare and capture registers
  // ***************************************
  // Capture two overrides a software write
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cmp1_q <= `MFT_RST_WORD;
      cmp2_q <= `MFT_RST_WORD;
      cap_q  <= `MFT_RST_WORD;
    end
    else
    begin
      if (wr_lo && wr_idx == 3'd2)
        cmp1_q[7:0] <= wdata_q[7:0];
      if (wr_hi && wr_idx == 3'd2)
        cmp1_q[15:8] <= wdata_q[15:8];
      // R17 capture two loads second value
      if (cap2_ev)
        cmp2_q <= cnt_q;
      else
      begin
        if (wr_lo && wr_idx == 3'd3)
          cmp2_q[7:0] <= wdata_q[7:0];
        if (wr_hi && wr_idx == 3'd3)
          cmp2_q[15:8] <= wdata_q[15:8];
      end
      // R17 capture one loads capture
      if (cap1_ev)
        cap_q <= cnt_q;
    end
  end

  // ***************************************
  // Counter and waveform
  // ***************************************
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cnt_q  <= `MFT_RST_WORD;
      sel2_q <= 1'b0;
      wave_q <= 1'b0;
    end
    else
    begin
      // R15 restart and alternate
      if (restart)
      begin
        cnt_q  <= `MFT_RST_WORD;
        sel2_q <= ~sel2_q;
      end
      else if (tick)
        cnt_q <= cnt_q + 16'h0001;
      // R15 R16 output high while second value is active, not in software mode
      // Following the active value keeps the phase right after a mode change
      if (restart && mode != MFT_SW)
        wave_q <= ~sel2_q;
      // R18 capture mode match toggles
      else if (match && cc)
        wave_q <= ~wave_q;
    end
  end

  // ***************************************
  // Real-time counter
  // ***************************************
  // Free-running, independent of the timer
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      rtc_q <= `MFT_RST_BYTE;
    else
      rtc_q <= rtc_q + 8'h01;
  end

  // ***************************************
  // AXI4-Lite write path
  // ***************************************
  // Address and data taken in either order
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `MFT_RESP_OK;
    end
    else
    begin
      if (s_axi_awvalid_i && awready_q)
      begin
        awaddr_q  <= s_axi_awaddr_i;
        aw_have_q <= 1'b1;
        awready_q <= 1'b0;
      end
      if (s_axi_wvalid_i && wready_q)
      begin
        wdata_q  <= s_axi_wdata_i;
        wstrb_q  <= s_axi_wstrb_i;
        w_have_q <= 1'b1;
        wready_q <= 1'b0;
      end
      // Commit and answer
      if (wr_en)
      begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= (wr_idx == 3'd7) ? `MFT_RESP_ERR : `MFT_RESP_OK;
      end
      // Response taken, reopen both channels
      if (bvalid_q && s_axi_bready_i)
      begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // ***************************************
  // AXI4-Lite read path
  // ***************************************
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rresp_q   <= `MFT_RESP_OK;
      rdata_q   <= '0;
    end
    else
    begin
      if (s_axi_arvalid_i && arready_q)
      begin
        arready_q <= 1'b0;
        rvalid_q  <= 1'b1;
        rresp_q   <= `MFT_RESP_OK;
        case (reg_idx(s_axi_araddr_i))
          3'd0:    rdata_q <= {24'h00_0000, ctrl_a_q};
          3'd1:    rdata_q <= {24'h00_0000, ctrl_b_q};
          3'd2:    rdata_q <= {16'h0000, cmp1_q};
          3'd3:    rdata_q <= {16'h0000, cmp2_q};
          3'd4:    rdata_q <= {16'h0000, cap_q};
          3'd5:    rdata_q <= {16'h0000, cnt_q};
          3'd6:    rdata_q <= {24'h00_0000, rtc_q};
          default:
          begin
            rdata_q <= '0;
            rresp_q <= `MFT_RESP_ERR;
          end
        endcase
      end
      if (rvalid_q && s_axi_rready_i)
      begin
        rvalid_q  <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  // ***************************************
  // Outputs
  // ***************************************
  assign s_axi_awready_o = awready_q;
  assign s_axi_wready_o  = wready_q;
  assign s_axi_bvalid_o  = bvalid_q;
  assign s_axi_bresp_o   = bresp_q;
  assign s_axi_arready_o = arready_q;
  assign s_axi_rvalid_o  = rvalid_q;
  assign s_axi_rresp_o   = rresp_q;
  assign s_axi_rdata_o   = rdata_q;
  assign wave_o          = wave_q;
  assign irq_o           = irq_q;

  // ***************************************
  // Assertions
  // ***************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);

  sequence s_cap1;
    cap1_ev;
  endsequence

  sequence s_cap2;
    cap2_ev;
  endsequence

  sequence s_pwm_match;
    restart && mode == MFT_PWM;
  endsequence

  // R4 capture one flag
  capture_one_flag_a : assert property (s_cap1 |=> ctrl_a_q[`MFT_A_CPF1] && cap_q == $past(cnt_q)) // R4
    else $error("capture one did not flag or load");

  // R3 capture two flag
  capture_two_flag_a : assert property (s_cap2 |=> ctrl_a_q[`MFT_A_CPF2] && cmp2_q == $past(cnt_q)) // R3
    else $error("capture two did not flag or load");

  // R15 restart and toggle
  pwm_restart_a : assert property (s_pwm_match |=> cnt_q == 16'h0000 && wave_q == sel2_q // R15
    && sel2_q != $past(sel2_q))
    else $error("pwm match did not restart and toggle");

  // R16 software output held
  sw_wave_hold_a : assert property (mode == MFT_SW ##1 mode == MFT_SW |-> $stable(wave_q)) // R16
    else $error("software mode moved the output");

  // R9 overflow flag set
  wrap_flag_a : assert property (wrap |=> ctrl_a_q[`MFT_A_OVF]) // R9
    else $error("wrap did not set overflow flag");

  // R20 set beats clear
  set_wins_a : assert property (wrap && wr_lo && wr_idx == 3'd0 |=> ctrl_a_q[`MFT_A_OVF]) // R20
    else $error("clear beat a simultaneous wrap");

  // R19 overflow interrupt
  ovf_irq_a : assert property (ctrl_a_q[`MFT_A_OVF] && ctrl_a_q[`MFT_A_OVIE] |-> irq_o) // R19
    else $error("overflow interrupt missing");

  // R10 real-time flag
  rt_flag_a : assert property (rt_wrap |=> ctrl_b_q[`MFT_B_RTOV] && rtc_q == 8'h00) // R10
    else $error("real-time wrap not flagged");

  // R18 capture mode keeps counting
  cc_no_restart_a : assert property (match && cc |=> cnt_q == $past(cnt_q) + 16'h0001) // R18
    else $error("capture mode match restarted the counter");

endmodule : mft_ctrl
`default_nettype wire

// ---- tb/mft_pin_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// ***************************
// Capture and event pin driver
// ***************************
module mft_pin_model (
  input  wire logic clk_i,
  output logic      cap1_o,
  output logic      cap2_o,
  output logic      event_o
);
  // All pins idle low
  initial
  begin
    cap1_o = 1'b0;
    cap2_o = 1'b0;
    event_o = 1'b0;
  end

  // full pulse, hold sets prompt or slow
  task automatic pulse(input int pin, input int hold);
    for (int k = 0; k < 2; k++)
    begin
      @(posedge clk_i);
      case (pin)
        0: cap1_o <= ~cap1_o;
        1: cap2_o <= ~cap2_o;
        default: event_o <= ~event_o;
      endcase
      repeat (hold) @(posedge clk_i);
    end
  endtask : pulse
endmodule : mft_pin_model
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "mft_consts.svh"
module testbench;
  logic        clk_i = 1'b0, arst_n_i = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [1:0]  bresp, rresp, resp;
  logic        bvalid, rvalid, awready, wready, arready, wave_o, irq_o, cap1, cap2, evt;
  logic [31:0] got, c0;
  int          fails = 0, num_checks = 0, a, b, n;

  // Clock at 100 MHz
  always #5 clk_i = ~clk_i;

  mft_pin_model pins (.clk_i(clk_i), .cap1_o(cap1), .cap2_o(cap2), .event_o(evt));
  mft_ctrl dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'h3), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .cap1_pin_i(cap1), .cap2_pin_i(cap2), .event_pin_i(evt), .wave_o(wave_o), .irq_o(irq_o));

  // Verdict and end of run
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  // Compare one value
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    num_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // AXI write, both channels offered together
  task automatic axw(input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk_i);
    awaddr <= ad; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge clk_i);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid)
      begin
        bready <= 1'b0;
        resp = bresp;
        return;
      end
    end
    fails++;
    give_verdict();
  endtask : axw

  // AXI read
  task automatic axr(input logic [7:0] ad);
    @(posedge clk_i);
    araddr <= ad; arvalid <= 1'b1; rready <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge clk_i);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid)
      begin
        rready <= 1'b0;
        got = rdata;
        resp = rresp;
        return;
      end
    end
    fails++;
    give_verdict();
  endtask : axr

  // Cycles until wave changes
  task automatic seg(output int len);
    logic w;
    w = wave_o;
    for (len = 0; wave_o === w && len < 600; len++) @(posedge clk_i);
    if (len == 600)
    begin
      fails++;
      give_verdict();
    end
  endtask : seg

  // Reset values, unmapped place, real-time wrap flag
  task automatic t_regs;
    axr(`MFT_OFF_B); chk("b_reset", 32'h0000_0000, got);
    axr(`MFT_OFF_A); chk("a_reset", 32'h0000_0000, got & 32'h0000_00E7);
    axr(8'h1C); chk("rd_unmapped", 32'h0000_0002, {30'd0, resp});
    axw(8'h20, 32'h0000_00FF); chk("wr_unmapped", 32'h0000_0002, {30'd0, resp});
    repeat (300) @(posedge clk_i);
    axr(`MFT_OFF_B); chk("rt_wrap", 32'h0000_0080, got);
    axw(`MFT_OFF_B, 32'h0000_0000); axr(`MFT_OFF_B); chk("rt_clear", 32'h0000_0000, got);
    $display("test regs done");
  endtask : t_regs

  // Captures, flags, capture interrupt
  task automatic t_capture;
    axw(`MFT_OFF_B, 32'h0000_0042); axw(`MFT_OFF_A, 32'h0000_0020);
    pins.pulse(0, 6);
    axr(`MFT_OFF_A); chk("cap1_flag", 32'h0000_0060, got & 32'h0000_00E0);
    chk("cap_irq", 32'h0000_0001, {31'd0, irq_o});
    pins.pulse(1, 2);
    axr(`MFT_OFF_A); chk("cap2_flag", 32'h0000_00E0, got & 32'h0000_00E0);
    axw(`MFT_OFF_A, 32'h0000_0020); axr(`MFT_OFF_A);
    chk("cap_clear", 32'h0000_0020, got & 32'h0000_00E0);
    chk("irq_off", 32'h0000_0000, {31'd0, irq_o});
    $display("test capture done");
  endtask : t_capture

  // PWM timing, compare flags and interrupt gating
  task automatic t_pwm;
    logic lv;
    axw(`MFT_OFF_CMP1, 32'h0000_0003); axw(`MFT_OFF_CMP2, 32'h0000_0007);
    axw(`MFT_OFF_A, 32'h0000_0004); axw(`MFT_OFF_B, 32'h0000_0005);
    seg(a);
    lv = wave_o;
    seg(a); seg(b);
    chk("pwm_hi_minus_lo", 32'd8, lv ? a - b : b - a);
    axr(`MFT_OFF_A); chk("cmp_flags", 32'h0000_001C, got & 32'h0000_001C);
    chk("cmp_irq", 32'h0000_0001, {31'd0, irq_o});
    axw(`MFT_OFF_A, 32'h0000_0000); repeat (3) @(posedge clk_i);
    chk("cmp_irq_off", 32'h0000_0000, {31'd0, irq_o});
    axw(`MFT_OFF_B, 32'h0000_0004); lv = wave_o; a = 0;
    repeat (60)
    begin
      @(posedge clk_i);
      if (wave_o !== lv) a++;
    end
    chk("sw_wave_still", 32'd0, a);
    $display("test pwm done");
  endtask : t_pwm

  // External event counting on rising edges
  task automatic t_event;
    axw(`MFT_OFF_CMP1, 32'h0000_FFFF); axw(`MFT_OFF_CMP2, 32'h0000_FFFF);
    axw(`MFT_OFF_B, 32'h0000_0023); axr(`MFT_OFF_CNT); c0 = got;
    repeat (3) pins.pulse(2, 5);
    axr(`MFT_OFF_CNT); chk("event_count", c0 + 32'd3, got);
    $display("test event done");
  endtask : t_event

  initial
  begin
    repeat (5) @(posedge clk_i);
    arst_n_i <= 1'b1;
    @(posedge clk_i);
    t_regs();
    t_pwm();
    t_capture();
    t_event();
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
